//--- crq_pkg.sv
// constants, field layouts and carrier types for completer request delivery
package crq_pkg;
  // datapath geometry
  localparam int BEAT_DWORDS = 8;
  localparam logic [3:0] DESC_DWORDS = 4'h4;
  localparam logic [3:0] ADDR_MODE_BASE = 4'h8;
  localparam logic [10:0] ZERO_LEN_DW_COUNT = 11'h001;
  // request type encodings
  localparam logic [3:0] REQ_MEM_RD = 4'h0;
  localparam logic [3:0] REQ_MEM_WR = 4'h1;
  localparam logic [3:0] REQ_IO_RD = 4'h2;
  localparam logic [3:0] REQ_IO_WR = 4'h3;
  localparam logic [3:0] REQ_FETCH_ADD = 4'h4;
  localparam logic [3:0] REQ_SWAP = 4'h5;
  localparam logic [3:0] REQ_CAS = 4'h6;
  localparam logic [3:0] REQ_LOCKED_RD = 4'h7;
  localparam logic [3:0] REQ_CFG0_RD = 4'h8;
  localparam logic [3:0] REQ_CFG1_RD = 4'h9;
  localparam logic [3:0] REQ_CFG0_WR = 4'ha;
  localparam logic [3:0] REQ_CFG1_WR = 4'hb;
  localparam logic [3:0] REQ_MSG = 4'hc;
  localparam logic [3:0] REQ_MSG_VENDOR = 4'hd;
  localparam logic [3:0] REQ_MSG_ATS = 4'he;
  localparam logic [3:0] REQ_RESERVED = 4'hf;
  localparam logic [2:0] ROUTE_BY_ID = 3'h2;
  // descriptor field positions
  localparam int DESC_ADDR_LSB = 2;
  localparam int DESC_DWCNT_LSB = 64;
  localparam int DESC_TYPE_LSB = 75;
  localparam int DESC_RID_LSB = 80;
  localparam int DESC_TAG_LSB = 96;
  localparam int DESC_FUNC_LSB = 104;
  localparam int DESC_BAR_LSB = 112;
  localparam int DESC_APER_LSB = 115;
  localparam int DESC_TC_LSB = 121;
  localparam int DESC_ATTR_LSB = 124;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_ALIGN_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // sequencing phases
  typedef enum logic {PH_IDLE, PH_RUN} phase_t;
  // parsed inbound request header
  typedef struct packed {
    logic [3:0] req_type;
    logic [63:0] addr;
    logic [10:0] dw_count;
    logic zero_len;
    logic has_payload;
    logic [15:0] req_id;
    logic [7:0] tag;
    logic [7:0] target_fn;
    logic [2:0] bar_id;
    logic [5:0] bar_aperture;
    logic [2:0] tc;
    logic [2:0] attr;
    logic [3:0] first_dword_byte_mask;
    logic [3:0] last_be;
    logic [7:0] msg_code;
    logic [2:0] msg_route;
    logic [15:0] msg_dest_id;
    logic [31:0] hdr_dw2;
    logic [31:0] hdr_dw3;
    logic tph_present;
    logic [7:0] tph_st_tag;
    logic [1:0] tph_st_type;
  } req_hdr_t;
  // sideband beside each beat
  typedef struct packed {
    logic sop;
    logic [3:0] first_dword_byte_mask;
    logic [3:0] last_dword_byte_mask;
    logic [31:0] byte_en;
    logic tph_present;
    logic [7:0] tph_st_tag;
    logic [1:0] tph_st_type;
  } request_sideband_t;
  // wishbone master request
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage

//--- completer_request_delivery.sv
// completer request framer: descriptor plus realigned payload onto a 256-bit stream
// Notes on behaviour
// (RULE_01) message code into descriptor bits 111:104
// (RULE_02) message routing subfield copied into descriptor
// (RULE_03) routed-by-ID vendor message: destination in 15:0
// (RULE_04) vendor dword 3 at 63:32, ATS dwords 2-3
// (RULE_05) memory, I/O and atomic type codes
// (RULE_06) locked read and configuration type codes
// (RULE_07) message, vendor, ATS and reserved type codes
// (RULE_08) write packets: descriptor first, then payload
// (RULE_09) valid held through packet; ready may stall; valid here drops mid-packet while pay_valid_i is low for a needed payload beat
// (RULE_10) keep contiguous; zeros only in last beat
// (RULE_11) last flagged on final beat
// (RULE_12) first/last byte masks valid in first beat
// (RULE_13) start flag on descriptor beat
// (RULE_14) byte strobes only on real payload bytes
// (RULE_15) strobes contiguous except one/two dword payloads
// (RULE_16) zero-length write: one dword, strobes clear
// (RULE_17) dword mode: byte gap from first address
// (RULE_18) hint tag and type on sideband
// (RULE_19) address mode: payload next beat, address lane
// (RULE_20) reads are descriptor only, one beat
// (RULE_21) zero-length read: count one, masks zero
// (RULE_22) user answers reads with ordered completions
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
module completer_request_delivery (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // parsed request header
  input wire crq_pkg::req_hdr_t hdr_i,
  input wire logic hdr_valid_i,
  output logic hdr_ready_o,
  // payload beats, dword 0 in the low lane
  input wire logic [255:0] pay_data_i,
  input wire logic pay_valid_i,
  output logic pay_ready_o,
  // request delivery port
  output logic request_stream_valid_o,
  input wire logic request_stream_ready_i,
  output logic [255:0] request_stream_data_o,
  output logic [7:0] request_stream_dword_keep_o,
  output logic request_stream_last_o,
  output crq_pkg::request_sideband_t request_sideband_bus_o,
  // wishbone slave
  input wire crq_pkg::wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o
);

  // whole module state
  typedef struct packed {
    crq_pkg::phase_t phase;
    logic [11:0] n;        // index of next beat to build
    logic [3:0] p;         // dword position of first payload dword
    logic [10:0] d;        // payload dwords
    logic [7:0] in_left;   // payload input beats still to take
    logic [3:0] fbe;
    logic [3:0] lbe;
    logic tph;
    logic [7:0] st_tag;
    logic [1:0] st_type;
    logic [255:0] prev;    // last payload beat taken
    logic ovalid;
    logic [255:0] odata;
    logic [7:0] okeep;
    logic olast;
    crq_pkg::request_sideband_t oside;
    logic [1:0] ctrl;
    logic [15:0] pkt_count;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // descriptor assembly from a parsed header
  function automatic logic [127:0] build_desc(input crq_pkg::req_hdr_t h);
    logic [127:0] dsc;
    logic [10:0] cnt;
    dsc = '0;
    cnt = h.zero_len ? crq_pkg::ZERO_LEN_DW_COUNT : h.dw_count; // RULE_21
    dsc[crq_pkg::DESC_DWCNT_LSB +: 11] = cnt;
    dsc[crq_pkg::DESC_TYPE_LSB +: 4] = h.req_type; // RULE_05
    dsc[crq_pkg::DESC_RID_LSB +: 16] = h.req_id;
    dsc[crq_pkg::DESC_TAG_LSB +: 8] = h.tag;
    dsc[crq_pkg::DESC_TC_LSB +: 3] = h.tc;
    dsc[crq_pkg::DESC_ATTR_LSB +: 3] = h.attr;
    if (h.req_type >= crq_pkg::REQ_MSG && h.req_type != crq_pkg::REQ_RESERVED) // RULE_07
    begin
      // message layout
      dsc[crq_pkg::DESC_FUNC_LSB +: 8] = h.msg_code; // RULE_01
      dsc[crq_pkg::DESC_BAR_LSB +: 3] = h.msg_route; // RULE_02
      if (h.req_type == crq_pkg::REQ_MSG_VENDOR)
      begin
        dsc[63:32] = h.hdr_dw3; // RULE_04
        if (h.msg_route == crq_pkg::ROUTE_BY_ID)
        begin
          dsc[15:0] = h.msg_dest_id; // RULE_03
        end
      end
      else if (h.req_type == crq_pkg::REQ_MSG_ATS)
      begin
        dsc[63:0] = {h.hdr_dw3, h.hdr_dw2}; // RULE_04
      end
    end
    else
    begin
      // memory, I/O, atomic and legacy layout
      dsc[63:0] = h.addr; // RULE_06
      dsc[crq_pkg::DESC_FUNC_LSB +: 8] = h.target_fn;
      dsc[crq_pkg::DESC_BAR_LSB +: 3] = h.bar_id;
      dsc[crq_pkg::DESC_APER_LSB +: 6] = h.bar_aperture;
    end
    return dsc;
  endfunction

  // beat builder locals
  logic can_load;
  logic take_hdr;
  logic need_pop;
  logic load;
  logic last_c;
  logic is_msg;
  logic [11:0] n_c;
  logic [3:0] p_c;
  logic [10:0] d_c;
  logic [7:0] inl_c;
  logic [3:0] fbe_c;
  logic [3:0] lbe_c;
  logic [2:0] s_c;
  logic [11:0] abs_c;
  logic [11:0] idx_c;
  logic [255:0] bdata;
  logic [7:0] bkeep;
  logic [31:0] bbe;

  // next-state logic: beat building, output hold, register file
  always_comb
  begin
    st_nxt = st_r;
    can_load = !st_r.ovalid || request_stream_ready_i;
    bdata = '0;
    bkeep = '0;
    bbe = '0;
    abs_c = '0;
    idx_c = '0;
    is_msg = hdr_i.req_type >= crq_pkg::REQ_MSG;
    // beat accepted downstream
    if (st_r.ovalid && request_stream_ready_i)
    begin
      st_nxt.ovalid = 1'b0;
      if (st_r.olast)
      begin
        st_nxt.pkt_count = st_r.pkt_count + 16'h0001;
      end
    end
    take_hdr = st_r.phase == crq_pkg::PH_IDLE && st_r.ctrl[crq_pkg::CTRL_ENABLE_BIT] && hdr_valid_i;
    // packet geometry from header or from held state
    if (st_r.phase == crq_pkg::PH_IDLE)
    begin
      n_c = '0;
      d_c = hdr_i.has_payload ? (hdr_i.zero_len ? crq_pkg::ZERO_LEN_DW_COUNT : hdr_i.dw_count) : 11'h000; // RULE_16
      if (!hdr_i.has_payload || !st_r.ctrl[crq_pkg::CTRL_ALIGN_BIT])
      begin
        p_c = crq_pkg::DESC_DWORDS; // RULE_08
      end
      else
      begin
        p_c = crq_pkg::ADDR_MODE_BASE + (is_msg ? 4'h0 : {1'b0, hdr_i.addr[4:2]}); // RULE_19
      end
      inl_c = 8'((12'(d_c) + 12'h007) >> 3);
      fbe_c = hdr_i.zero_len ? 4'h0 : hdr_i.first_dword_byte_mask; // RULE_21
      lbe_c = hdr_i.zero_len ? 4'h0 : hdr_i.last_be;
    end
    else
    begin
      n_c = st_r.n;
      d_c = st_r.d;
      p_c = st_r.p;
      inl_c = st_r.in_left;
      fbe_c = st_r.fbe;
      lbe_c = st_r.lbe;
    end
    s_c = p_c[2:0];
    // a beat reaching the payload region consumes one input beat while input beats remain
    need_pop = inl_c != 8'h00 && ((n_c << 3) + 12'h008) > 12'(p_c);
    load = can_load && (take_hdr || st_r.phase == crq_pkg::PH_RUN) && (!need_pop || pay_valid_i);
    last_c = ((n_c << 3) + 12'h008) >= (12'(p_c) + 12'(d_c)); // RULE_11
    // per-lane placement
    for (int l = 0; l < crq_pkg::BEAT_DWORDS; l++)
    begin
      abs_c = (n_c << 3) + 12'(l);
      idx_c = abs_c - 12'(p_c);
      if (abs_c < 12'(p_c))
      begin
        bkeep[l] = 1'b1; // RULE_10
      end
      else if (idx_c < 12'(d_c))
      begin
        bkeep[l] = 1'b1;
        // lanes at or above the shift come from the new beat
        if (3'(l) >= s_c)
        begin
          bdata[l*32 +: 32] = pay_data_i[32*(l - int'(s_c)) +: 32];
        end
        else
        begin
          bdata[l*32 +: 32] = st_r.prev[32*(l + 8 - int'(s_c)) +: 32];
        end
        // byte strobes from the dword masks
        if (idx_c == 12'h000)
        begin
          bbe[l*4 +: 4] = fbe_c; // RULE_17
        end
        else if (idx_c == 12'(d_c) - 12'h001)
        begin
          bbe[l*4 +: 4] = lbe_c; // RULE_15
        end
        else
        begin
          bbe[l*4 +: 4] = 4'hf; // RULE_14
        end
      end
    end
    // load a new output beat
    if (load)
    begin
      st_nxt.ovalid = 1'b1; // RULE_09
      st_nxt.odata = bdata;
      st_nxt.okeep = bkeep;
      st_nxt.olast = last_c;
      st_nxt.oside.byte_en = bbe;
      st_nxt.oside.sop = n_c == 12'h000; // RULE_13
      st_nxt.n = n_c + 12'h001;
      st_nxt.in_left = need_pop ? inl_c - 8'h01 : inl_c;
      st_nxt.phase = last_c ? crq_pkg::PH_IDLE : crq_pkg::PH_RUN;
      if (need_pop)
      begin
        st_nxt.prev = pay_data_i;
      end
      if (take_hdr)
      begin
        st_nxt.odata[127:0] = build_desc(hdr_i); // RULE_20
        st_nxt.p = p_c;
        st_nxt.d = d_c;
        st_nxt.fbe = fbe_c;
        st_nxt.lbe = lbe_c;
        st_nxt.oside.first_dword_byte_mask = fbe_c; // RULE_12
        st_nxt.oside.last_dword_byte_mask = lbe_c;
        st_nxt.oside.tph_present = hdr_i.tph_present; // RULE_18
        st_nxt.oside.tph_st_tag = hdr_i.tph_st_tag;
        st_nxt.oside.tph_st_type = hdr_i.tph_st_type;
      end
    end
    // wishbone: one-cycle answer, unmapped reads zero
    st_nxt.ack = wb_i.cyc && wb_i.stb && !st_r.ack;
    st_nxt.rdata = '0;
    if (wb_i.cyc && wb_i.stb && !st_r.ack)
    begin
      unique case (wb_i.adr)
        crq_pkg::REG_CTRL:
        begin
          st_nxt.rdata = {30'h0, st_r.ctrl};
          if (wb_i.we && wb_i.sel[0])
          begin
            st_nxt.ctrl = wb_i.dat[1:0];
          end
        end
        crq_pkg::REG_STATUS:
        begin
          st_nxt.rdata = {st_r.pkt_count, 14'h0, st_r.phase == crq_pkg::PH_RUN, st_r.ovalid};
        end
        default:
        begin
          st_nxt.rdata = '0;
        end
      endcase
    end
    hdr_ready_o = take_hdr && load;
    pay_ready_o = load && need_pop;
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
      st_r.phase <= crq_pkg::PH_IDLE;
      st_r.ctrl <= crq_pkg::CTRL_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs from the state register
  assign request_stream_valid_o = st_r.ovalid;
  assign request_stream_data_o = st_r.odata;
  assign request_stream_dword_keep_o = st_r.okeep;
  assign request_stream_last_o = st_r.olast;
  assign request_sideband_bus_o = st_r.oside;
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;

  // inside-packet tracker, read only by checks
  logic in_pkt_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_pkt_r <= 1'b0;
    end
    else if (st_r.ovalid && request_stream_ready_i)
    begin
      in_pkt_r <= !st_r.olast;
    end
  end

  valid_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    st_r.ovalid && !request_stream_ready_i |=> st_r.ovalid && $stable(st_r.odata) && $stable(st_r.olast))
    else $error("beat changed while stalled");
  sop_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    st_r.ovalid |-> st_r.oside.sop == !in_pkt_r)
    else $error("start flag not on first beat");
  keep_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    st_r.ovalid |-> (!st_r.olast ? st_r.okeep == 8'hff : ((st_r.okeep & (st_r.okeep + 8'h01)) == 8'h00)))
    else $error("keep not contiguous");
  desc_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
    st_r.ovalid && st_r.oside.sop |-> st_r.oside.byte_en[15:0] == 16'h0000)
    else $error("strobe on descriptor bytes");
  read_single_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_20
    hdr_ready_o && hdr_i.req_type == crq_pkg::REQ_MEM_RD && !hdr_i.has_payload |=> st_r.olast && st_r.okeep == 8'h0f)
    else $error("read not a single descriptor beat");
  msg_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    hdr_ready_o && hdr_i.req_type == crq_pkg::REQ_MSG |=> st_r.odata[111:104] == $past(hdr_i.msg_code)
    && st_r.odata[114:112] == $past(hdr_i.msg_route))
    else $error("message code or routing misplaced");
  vendor_dest_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    hdr_ready_o && hdr_i.req_type == crq_pkg::REQ_MSG_VENDOR && hdr_i.msg_route == crq_pkg::ROUTE_BY_ID
    |=> st_r.odata[15:0] == $past(hdr_i.msg_dest_id) && st_r.odata[63:32] == $past(hdr_i.hdr_dw3))
    else $error("vendor destination misplaced");
  zero_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_21
    hdr_ready_o && hdr_i.zero_len |=> st_r.odata[74:64] == 11'h001
    && st_r.oside.first_dword_byte_mask == 4'h0 && st_r.oside.last_dword_byte_mask == 4'h0)
    else $error("zero-length request mis-sized");
  type_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    hdr_ready_o |=> st_r.odata[78:75] == $past(hdr_i.req_type) && st_r.oside.sop)
    else $error("request type not copied");
  tph_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
    hdr_ready_o && hdr_i.tph_present |=> st_r.oside.tph_st_tag == $past(hdr_i.tph_st_tag)
    && st_r.oside.tph_st_type == $past(hdr_i.tph_st_type))
    else $error("hint parameters lost");
  // register answer lasts exactly one cycle
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("register answer longer than one cycle");
  // first beat carries the header byte masks
  mask_copy_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    hdr_ready_o && !hdr_i.zero_len |=> st_r.oside.first_dword_byte_mask == $past(hdr_i.first_dword_byte_mask)
    && st_r.oside.last_dword_byte_mask == $past(hdr_i.last_be) && st_r.oside.sop)
    else $error("byte masks not on first beat");
  zero_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
    hdr_ready_o && hdr_i.zero_len && hdr_i.has_payload && !st_r.ctrl[crq_pkg::CTRL_ALIGN_BIT]
    |=> st_r.olast && st_r.okeep == 8'h1f && st_r.oside.byte_en == 32'h0)
    else $error("zero-length write not one empty dword");
  addr_gap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_19
    hdr_ready_o && hdr_i.has_payload && st_r.ctrl[crq_pkg::CTRL_ALIGN_BIT]
    |=> st_r.okeep == 8'hff && st_r.oside.byte_en == 32'h0 && !st_r.olast)
    else $error("address mode payload shares descriptor beat");

endmodule

//--- crq_user_sink.sv
// user-side sink model for the request delivery port
module crq_user_sink (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stretch beats when high
  input wire logic stall_i,
  // request delivery port
  input wire logic valid_i,
  input wire logic sop_i,
  input wire logic [255:0] data_i,
  output logic ready_o,
  // count of reads answered
  output int done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pend_q[$]; // tags of reads awaiting completion
  logic alt_r; // toggles to pace a stalled sink
  // ready pacing, then in-order completion of accepted memory reads
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_o <= 1'b0;
      alt_r <= 1'b0;
      done_o <= 0;
      pend_q.delete();
    end
    else
    begin
      alt_r <= ~alt_r;
      // every other cycle while stalling
      ready_o <= !stall_i || alt_r;
      if (valid_i && ready_o && sop_i && data_i[78:75] == crq_pkg::REQ_MEM_RD)
        pend_q.push_back(data_i[103:96]);
      else if (pend_q.size() > 0)
      begin
        // oldest read answered first
        void'(pend_q.pop_front());
        done_o <= done_o + 1;
      end
    end
  end
endmodule

//--- completer_request_delivery_tb.sv
// self-checking bench for completer request delivery
module completer_request_delivery_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i;
  logic rst_i;
  crq_pkg::req_hdr_t hdr_i;
  logic hdr_valid_i;
  logic hdr_ready_o;
  logic [255:0] pay_data_i;
  logic pay_valid_i;
  logic pay_ready_o;
  logic request_stream_valid_o;
  logic request_stream_ready_i;
  logic [255:0] request_stream_data_o;
  logic [7:0] request_stream_dword_keep_o;
  logic request_stream_last_o;
  crq_pkg::request_sideband_t request_sideband_bus_o;
  crq_pkg::wb_req_t wb_i;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic stall; // sink pacing select
  int done; // reads answered by the sink
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0; // cycle count for the hang limit
  logic hold_r = 1'b0; // beat was stalled last cycle
  logic [255:0] hold_d; // data of the stalled beat
  logic [255:0] pb[4]; // payload beats offered
  logic [255:0] cd[$]; // captured beat data
  logic [7:0] ck[$]; // captured keep
  logic cl[$]; // captured last
  crq_pkg::request_sideband_t cs[$]; // captured sideband
  crq_pkg::req_hdr_t h;
  logic [31:0] rd; // last register read

  completer_request_delivery completer_request_delivery_inst (.clk_i, .rst_i, .hdr_i, .hdr_valid_i, .hdr_ready_o,
    .pay_data_i, .pay_valid_i, .pay_ready_o, .request_stream_valid_o, .request_stream_ready_i,
    .request_stream_data_o, .request_stream_dword_keep_o, .request_stream_last_o, .request_sideband_bus_o,
    .wb_i, .wb_ack_o, .wb_dat_o);

  crq_user_sink crq_user_sink_inst (.clk_i, .rst_i, .stall_i(stall), .valid_i(request_stream_valid_o),
    .sop_i(request_sideband_bus_o.sop), .data_i(request_stream_data_o), .ready_o(request_stream_ready_i),
    .done_o(done));

  // clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [263:0] g, input logic [263:0] e, input string m);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // capture accepted beats, watch stalled beats, cut hangs
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (hold_r)
      chk({request_stream_valid_o, request_stream_data_o}, {1'b1, hold_d}, "stalled beat moved");
    hold_r <= request_stream_valid_o && !request_stream_ready_i;
    hold_d <= request_stream_data_o;
    if (request_stream_valid_o && request_stream_ready_i)
    begin
      cd.push_back(request_stream_data_o);
      ck.push_back(request_stream_dword_keep_o);
      cl.push_back(request_stream_last_o);
      cs.push_back(request_sideband_bus_o);
    end
    if (cyc == 3000)
    begin
      n_fail++;
      $display("Error %0t timeout", $time);
      close_out();
    end
  end

  // classic wishbone single cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask

  // offer one header and nb payload beats, then wait for the last beat out
  task automatic put(input crq_pkg::req_hdr_t x, input int nb, input logic s);
    int k;
    logic ht;
    @(posedge clk_i);
    k = 0;
    ht = 1'b0;
    cd.delete();
    ck.delete();
    cl.delete();
    cs.delete();
    stall <= s;
    hdr_i <= x;
    hdr_valid_i <= 1'b1;
    pay_valid_i <= (nb > 0);
    pay_data_i <= pb[0];
    while (!ht || k < nb)
    begin
      @(posedge clk_i);
      if (!ht && hdr_ready_o === 1'b1)
      begin
        ht = 1'b1;
        hdr_valid_i <= 1'b0;
      end
      if (k < nb && pay_ready_o === 1'b1)
      begin
        k++;
        pay_valid_i <= (k < nb);
        pay_data_i <= pb[k % 4];
      end
    end
    do
    begin
      @(posedge clk_i);
      #1;
    end
    while (cl.size() == 0 || cl[cl.size() - 1] !== 1'b1);
  endtask

  // one output beat against its expectation
  task automatic eb(input int i, input logic [255:0] d, input logic [255:0] m, input logic [7:0] k,
    input logic [31:0] be);
    chk(cd[i] & m, d & m, "data");
    chk(ck[i], k, "keep");
    chk(cs[i].byte_en, be, "byte_en");
    chk({cs[i].sop, cl[i]}, {i == 0, i == cd.size() - 1}, "sop last");
  endtask

  // payload dword n
  function automatic logic [31:0] pd(input int n);
    return 32'ha000_0000 + n;
  endfunction

  initial
  begin
    rst_i = 1'b1;
    hdr_i = '0;
    hdr_valid_i = 1'b0;
    pay_data_i = '0;
    pay_valid_i = 1'b0;
    wb_i = '0;
    stall = 1'b0;
    for (int i = 0; i < 32; i++)
      pb[i / 8][32 * (i % 8) +: 32] = pd(i);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, crq_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h2, "ctrl after reset");
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    // type codes 0 to 14, descriptor only, odd ones stalled
    for (int t = 0; t < 15; t++)
    begin
      h = '0;
      h.req_type = t[3:0];
      h.dw_count = 11'h001;
      h.first_dword_byte_mask = 4'hf;
      h.target_fn = 8'h20 + t[7:0];
      h.msg_code = 8'h70 + t[7:0];
      h.msg_route = crq_pkg::ROUTE_BY_ID;
      h.msg_dest_id = 16'hbeef;
      h.hdr_dw2 = 32'hd2d2_0000 + t;
      h.hdr_dw3 = 32'hc0de_0000 + t;
      put(h, 0, t[0]);
      chk(cd.size(), 1, "beat count");
      chk(cd[0][78:75], t[3:0], "type");
      eb(0, 256'h0, 256'h0, 8'h0f, 32'h0);
      if (t > 11)
      begin
        chk(cd[0][111:104], h.msg_code, "message code");
        chk(cd[0][114:112], 3'h2, "routing");
      end
      if (t == 13)
        chk(cd[0][63:0], {h.hdr_dw3, 16'h0, 16'hbeef}, "vendor header");
      if (t == 14)
        chk(cd[0][63:0], {h.hdr_dw3, h.hdr_dw2}, "ats header");
    end
    // zero-length read
    h = '0;
    h.zero_len = 1'b1;
    h.first_dword_byte_mask = 4'hf;
    h.last_be = 4'hf;
    put(h, 0, 1'b0);
    chk({cd[0][74:64], cs[0].first_dword_byte_mask, cs[0].last_dword_byte_mask}, 19'h00100, "zero read");
    // five dword write, dword mode, stalled, with hint
    h = '0;
    h.req_type = crq_pkg::REQ_MEM_WR;
    h.has_payload = 1'b1;
    h.addr = 64'h1002;
    h.dw_count = 11'h005;
    h.first_dword_byte_mask = 4'hc;
    h.last_be = 4'h3;
    h.tph_present = 1'b1;
    h.tph_st_tag = 8'h5a;
    h.tph_st_type = 2'h2;
    put(h, 1, 1'b1);
    chk(cd.size(), 2, "beat count");
    chk(cd[0][78:75], crq_pkg::REQ_MEM_WR, "type");
    eb(0, {pd(3), pd(2), pd(1), pd(0), 128'h0}, {{128{1'b1}}, 128'h0}, 8'hff, 32'hfffc_0000);
    eb(1, {224'h0, pd(4)}, {224'h0, 32'hffff_ffff}, 8'h01, 32'h3);
    chk({cs[0].first_dword_byte_mask, cs[0].last_dword_byte_mask}, 8'hc3, "byte masks");
    chk({cs[0].tph_present, cs[0].tph_st_tag, cs[0].tph_st_type}, 11'h56a, "hint");
    // three dword write, address mode, lane 6
    wb(1'b1, crq_pkg::REG_CTRL, 32'h3);
    h.addr = 64'h101a;
    h.dw_count = 11'h003;
    h.tph_present = 1'b0;
    put(h, 1, 1'b0);
    chk(cd.size(), 3, "beat count");
    eb(0, 256'h0, 256'h0, 8'hff, 32'h0);
    eb(1, {pd(1), pd(0), 192'h0}, {{64{1'b1}}, 192'h0}, 8'hff, 32'hfc00_0000);
    eb(2, {224'h0, pd(2)}, {224'h0, 32'hffff_ffff}, 8'h01, 32'h3);
    // zero-length write, dword mode
    wb(1'b1, crq_pkg::REG_CTRL, 32'h2);
    h.addr = 64'h1000;
    h.zero_len = 1'b1;
    h.dw_count = 11'h000;
    h.first_dword_byte_mask = 4'hf;
    put(h, 1, 1'b0);
    chk(cd.size(), 1, "beat count");
    eb(0, 256'h0, 256'h0, 8'h1f, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(done, 2, "reads answered");
    // nineteen packets delivered, nothing pending
    wb(1'b0, crq_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0013_0000, "status after run");
    close_out();
  end
endmodule
